/* File: rtl/pwm16_pkg.sv */
// Constants, register map and types shared by the dual-slope timer files
package pwm16_pkg;
    // Widths
    localparam int unsigned CNT_W = 16;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned PRESC_W = 10;
    localparam int unsigned CHANNELS = 2;

    // Register word indexes on the Avalon address
    localparam logic [ADDR_W-1:0] REG_CTRL = 3'h0;
    localparam logic [ADDR_W-1:0] REG_COUNT = 3'h1;
    localparam logic [ADDR_W-1:0] REG_CMP_A = 3'h2;
    localparam logic [ADDR_W-1:0] REG_CMP_B = 3'h3;
    localparam logic [ADDR_W-1:0] REG_CAP_TOP = 3'h4;
    localparam logic [ADDR_W-1:0] REG_FLAGS = 3'h5;
    localparam logic [ADDR_W-1:0] REG_STATUS = 3'h6;

    // Control register fields
    localparam int unsigned CTRL_WGM_LSB = 0;
    localparam int unsigned CTRL_COMA_LSB = 4;
    localparam int unsigned CTRL_COMB_LSB = 6;
    localparam int unsigned CTRL_CS_LSB = 8;
    localparam int unsigned CTRL_DIRA_BIT = 11;
    localparam int unsigned CTRL_DIRB_BIT = 12;
    localparam logic [DATA_W-1:0] CTRL_MASK = 32'h0000_1fff;
    localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0000;

    // Flag register bits, write one to clear
    localparam int unsigned FLAG_OVF = 0;
    localparam int unsigned FLAG_CMPA = 1;
    localparam int unsigned FLAG_CMPB = 2;
    localparam int unsigned FLAG_CAP = 3;
    localparam int unsigned FLAG_W = 4;

    // Count register read-back: direction bit above the count
    localparam int unsigned COUNT_DIR_BIT = 16;

    // Waveform modes handled here
    localparam logic [3:0] WGM_PC_8 = 4'h1;
    localparam logic [3:0] WGM_PC_9 = 4'h2;
    localparam logic [3:0] WGM_PC_10 = 4'h3;
    localparam logic [3:0] WGM_PFC_CAP = 4'h8;
    localparam logic [3:0] WGM_PFC_CMPA = 4'h9;
    localparam logic [3:0] WGM_PC_CAP = 4'ha;
    localparam logic [3:0] WGM_PC_CMPA = 4'hb;
    localparam int unsigned WGM_TOPBIT = 3;

    // Fixed top values and counter bottom
    localparam logic [CNT_W-1:0] TOP_8 = 16'h00ff;
    localparam logic [CNT_W-1:0] TOP_9 = 16'h01ff;
    localparam logic [CNT_W-1:0] TOP_10 = 16'h03ff;
    localparam logic [CNT_W-1:0] CNT_BOTTOM = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_FULL = 16'hffff;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

    // Output mode field codes
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_NONINV = 2'h2;
    localparam logic [1:0] COM_INV = 2'h3;

    // Clock select codes: stopped, divide by 1, 8, 64, 256, 1024
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [PRESC_W-1:0] MASK_DIV1 = 10'h000;
    localparam logic [PRESC_W-1:0] MASK_DIV8 = 10'h007;
    localparam logic [PRESC_W-1:0] MASK_DIV64 = 10'h03f;
    localparam logic [PRESC_W-1:0] MASK_DIV256 = 10'h0ff;
    localparam logic [PRESC_W-1:0] MASK_DIV1024 = 10'h3ff;

    // Counting direction
    typedef enum logic {DIR_UP, DIR_DOWN} count_dir_t;
endpackage : pwm16_pkg

/* File: rtl/tick_if.sv */
// Carrier between the timer core and its prescaler
`timescale 1ns/1ps
interface tick_if;
    logic [2:0] clock_sel;
    logic tick;
    modport timer (output clock_sel, input tick);
    modport source (input clock_sel, output tick);
endinterface : tick_if

/* File: rtl/tick_prescaler.sv */
// Prescaler that turns the I/O clock into a one-cycle timer tick enable
`timescale 1ns/1ps
module tick_prescaler (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Select in, tick out
    tick_if.source port
);
    logic [pwm16_pkg::PRESC_W-1:0] div_ff;
    logic tick_ff;
    wire [pwm16_pkg::PRESC_W-1:0] div_mask;
    wire running;
    wire [pwm16_pkg::PRESC_W-1:0] nxt_div;
    wire nxt_tick;

    // Terminal mask per select; an unused code stops the timer
    assign div_mask = (port.clock_sel == pwm16_pkg::CS_DIV8) ? pwm16_pkg::MASK_DIV8 :
                      (port.clock_sel == pwm16_pkg::CS_DIV64) ? pwm16_pkg::MASK_DIV64 :
                      (port.clock_sel == pwm16_pkg::CS_DIV256) ? pwm16_pkg::MASK_DIV256 :
                      (port.clock_sel == pwm16_pkg::CS_DIV1024) ? pwm16_pkg::MASK_DIV1024 :
                      pwm16_pkg::MASK_DIV1;
    assign running = (port.clock_sel >= pwm16_pkg::CS_DIV1) && (port.clock_sel <= pwm16_pkg::CS_DIV1024);
    // Divider restarts while stopped so the first tick spacing is exact
    assign nxt_div = running ? div_ff + 10'h001 : '0;
    assign nxt_tick = running && ((div_ff & div_mask) == div_mask);
    assign port.tick = tick_ff;

    // Divider and tick register
    always_ff @(posedge clock) begin
        if (srst) begin
            div_ff <= '0;
            tick_ff <= 1'b0;
        end else begin
            div_ff <= nxt_div;
            tick_ff <= nxt_tick;
        end
    end
endmodule : tick_prescaler

/* File: rtl/dual_slope_pwm_timer16.sv */
// Dual-slope 16-bit PWM timer with Avalon-MM register slave
//
// The Avalon-MM slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// - Phase correct modes 1,2,3,10,11 count from zero up to top and back.
// - Top is 0x00FF, 0x01FF, 0x03FF, capture-top, or compare A per mode.
// - Counter stays at top for one tick, then counts down.
// - Non-inverting clears on up-count match, sets on down-count match; inverting reverses.
// - Output mode two gives non-inverted PWM, three gives inverted PWM.
// - Compare level reaches the pin only when its direction bit is output.
// - Phase correct mode sets the overflow flag at bottom.
// - Phase correct register top sets compare A or capture flag at top load.
// - Phase correct mode loads active compares from buffers at top.
// - Fixed top masks compare bits above the resolution on write.
// - Phase correct: compare at bottom gives steady low, at top steady high.
// - Phase and frequency correct uses mode 8 capture top or 9 compare A top.
// - Phase and frequency correct loads compares and sets overflow at bottom.
// - Phase and frequency correct sets compare A or capture flag at top.
// - Frequency correct: compare at bottom steady low, at top high.
// - Every compare match sets that channel's compare flag.
// - Tick is the I/O clock divided by 1, 8, 64, 256 or 1024.
// - Output mode one toggles channel A when top bit set; B disconnected.
// - Compare writes go to buffers; active values change at update point in dual-slope modes, and follow the buffer each clock otherwise.
// - Everything runs on the I/O clock; the tick is only an enable.
module dual_slope_pwm_timer16 (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Avalon-MM slave
    input wire logic [pwm16_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [pwm16_pkg::DATA_W-1:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [pwm16_pkg::DATA_W-1:0] readdata,
    output logic waitrequest,
    // Compare output pins
    output logic compare_a_pin_out,
    output logic compare_a_pin_oe,
    output logic compare_b_pin_out,
    output logic compare_b_pin_oe
);
    localparam int unsigned CW = pwm16_pkg::CNT_W;
    localparam int unsigned DW = pwm16_pkg::DATA_W;

    // Merge write data into an old word under the byte enables
    function automatic logic [DW-1:0] byte_merge(input logic [DW-1:0] old_word,
                                                 input logic [DW-1:0] new_word,
                                                 input logic [3:0] lanes);
        logic [DW-1:0] result;
        result = old_word;
        for (int b = 0; b < 4; b++) begin
            if (lanes[b]) begin
                result[b*8 +: 8] = new_word[b*8 +: 8];
            end
        end
        return result;
    endfunction : byte_merge

    // Registers
    logic ack_ff;
    logic [DW-1:0] ctrl_ff;
    logic [CW-1:0] count_value_ff;
    pwm16_pkg::count_dir_t dir_ff;
    logic [CW-1:0] capture_top_value_ff;
    logic [CW-1:0] cmp_buf_ff [pwm16_pkg::CHANNELS];
    logic [CW-1:0] cmp_act_ff [pwm16_pkg::CHANNELS];
    logic [pwm16_pkg::CHANNELS-1:0] oc_ff;
    logic [pwm16_pkg::FLAG_W-1:0] flags_ff;
    logic [DW-1:0] readdata_ff;
    logic pin_a_ff;
    logic pin_b_ff;
    logic oe_a_ff;
    logic oe_b_ff;

    // Prescaler carrier
    tick_if tick_bus ();
    tick_prescaler u_prescaler (
        .clock(clock),
        .srst(srst),
        .port(tick_bus.source)
    );

    // Bus handshake: one wait cycle, then the access completes
    wire req = read | write;
    wire nxt_ack = req & ~ack_ff;
    wire wr_fire = write & ack_ff;
    wire rd_load = read & ~ack_ff;
    assign waitrequest = req & ~ack_ff;
    assign readdata = readdata_ff;

    // Address decode
    wire sel_ctrl = address == pwm16_pkg::REG_CTRL;
    wire sel_count = address == pwm16_pkg::REG_COUNT;
    wire sel_cap = address == pwm16_pkg::REG_CAP_TOP;
    wire sel_flags = address == pwm16_pkg::REG_FLAGS;
    wire sel_status = address == pwm16_pkg::REG_STATUS;
    wire [pwm16_pkg::CHANNELS-1:0] sel_cmp = {address == pwm16_pkg::REG_CMP_B,
                                              address == pwm16_pkg::REG_CMP_A};

    // Control fields
    wire [3:0] waveform_mode_sel = ctrl_ff[pwm16_pkg::CTRL_WGM_LSB +: 4];
    wire top_mode_bit = waveform_mode_sel[pwm16_pkg::WGM_TOPBIT];
    wire [1:0] output_mode_sel [pwm16_pkg::CHANNELS];
    assign output_mode_sel[0] = ctrl_ff[pwm16_pkg::CTRL_COMA_LSB +: 2];
    assign output_mode_sel[1] = ctrl_ff[pwm16_pkg::CTRL_COMB_LSB +: 2];
    wire pin_direction_a = ctrl_ff[pwm16_pkg::CTRL_DIRA_BIT];
    wire pin_direction_b = ctrl_ff[pwm16_pkg::CTRL_DIRB_BIT];
    assign tick_bus.clock_sel = ctrl_ff[pwm16_pkg::CTRL_CS_LSB +: 3];
    wire timer_tick = tick_bus.tick;

    // Mode decode
    wire mode_pc = (waveform_mode_sel == pwm16_pkg::WGM_PC_8) | (waveform_mode_sel == pwm16_pkg::WGM_PC_9) |
                   (waveform_mode_sel == pwm16_pkg::WGM_PC_10) | (waveform_mode_sel == pwm16_pkg::WGM_PC_CAP) |
                   (waveform_mode_sel == pwm16_pkg::WGM_PC_CMPA);
    wire mode_pfc = (waveform_mode_sel == pwm16_pkg::WGM_PFC_CAP) |
                    (waveform_mode_sel == pwm16_pkg::WGM_PFC_CMPA);
    wire dual = mode_pc | mode_pfc;
    wire top_from_cap = (waveform_mode_sel == pwm16_pkg::WGM_PC_CAP) |
                        (waveform_mode_sel == pwm16_pkg::WGM_PFC_CAP);
    wire top_from_cmpa = (waveform_mode_sel == pwm16_pkg::WGM_PC_CMPA) |
                         (waveform_mode_sel == pwm16_pkg::WGM_PFC_CMPA);
    wire fixed_top = (waveform_mode_sel == pwm16_pkg::WGM_PC_8) | (waveform_mode_sel == pwm16_pkg::WGM_PC_9) |
                     (waveform_mode_sel == pwm16_pkg::WGM_PC_10);

    // Top value selection
    wire [CW-1:0] top_value = (waveform_mode_sel == pwm16_pkg::WGM_PC_8) ? pwm16_pkg::TOP_8 :
                              (waveform_mode_sel == pwm16_pkg::WGM_PC_9) ? pwm16_pkg::TOP_9 :
                              (waveform_mode_sel == pwm16_pkg::WGM_PC_10) ? pwm16_pkg::TOP_10 :
                              top_from_cap ? capture_top_value_ff :
                              cmp_act_ff[0];
    // Fixed top doubles as the mask of usable compare bits
    wire [CW-1:0] cmp_mask = fixed_top ? top_value : pwm16_pkg::CNT_FULL;

    // Counter position, and period events qualified by the tick enable
    wire at_top = count_value_ff == top_value;
    wire at_bottom = count_value_ff == pwm16_pkg::CNT_BOTTOM;
    wire run = timer_tick & dual;
    wire counting_up = dir_ff == pwm16_pkg::DIR_UP;
    wire top_ev = run & counting_up & at_top;
    wire bottom_ev = run & ~counting_up & at_bottom;
    // Phase correct updates at top, frequency correct at bottom
    wire load_ev = (mode_pc & top_ev) | (mode_pfc & bottom_ev);

    // Effective slope for output action: top always acts as down, bottom as up
    wire slope_up = at_top ? 1'b0 : (at_bottom ? 1'b1 : counting_up);

    // Register write data merged with byte enables
    wire [DW-1:0] ctrl_merged = byte_merge(ctrl_ff, writedata, byteenable);
    wire [DW-1:0] count_merged = byte_merge({{(DW-CW){1'b0}}, count_value_ff}, writedata, byteenable);
    wire [DW-1:0] cap_merged = byte_merge({{(DW-CW){1'b0}}, capture_top_value_ff}, writedata, byteenable);
    wire [DW-1:0] nxt_ctrl = (wr_fire & sel_ctrl) ? (ctrl_merged & pwm16_pkg::CTRL_MASK) : ctrl_ff;
    // Capture-top has no buffer: a write takes effect at once
    wire [CW-1:0] nxt_cap = (wr_fire & sel_cap) ? cap_merged[CW-1:0] : capture_top_value_ff;

    // Counter next value; a software write wins over counting
    wire count_wr = wr_fire & sel_count;
    wire [CW-1:0] cnt_up = count_value_ff + pwm16_pkg::CNT_ONE;
    wire [CW-1:0] cnt_dn = count_value_ff - pwm16_pkg::CNT_ONE;
    wire [CW-1:0] cnt_step = counting_up ? (at_top ? cnt_dn : cnt_up) :
                                           (at_bottom ? cnt_up : cnt_dn);
    wire [CW-1:0] nxt_count = count_wr ? count_merged[CW-1:0] : (run ? cnt_step : count_value_ff);
    wire turn_down = run & counting_up & at_top;
    wire turn_up = run & ~counting_up & at_bottom;
    wire pwm16_pkg::count_dir_t nxt_dir = ~dual ? pwm16_pkg::DIR_UP :
                                          turn_down ? pwm16_pkg::DIR_DOWN :
                                          turn_up ? pwm16_pkg::DIR_UP : dir_ff;

    // Per-channel buffer, active compare, match and output
    wire [pwm16_pkg::CHANNELS-1:0] match;
    wire [pwm16_pkg::CHANNELS-1:0] connected;
    wire [pwm16_pkg::CHANNELS-1:0] nxt_oc;
    for (genvar ch = 0; ch < pwm16_pkg::CHANNELS; ch++) begin : g_chan
        wire [DW-1:0] merged = byte_merge({{(DW-CW){1'b0}}, cmp_buf_ff[ch]}, writedata, byteenable);
        wire [CW-1:0] nxt_buf = (wr_fire & sel_cmp[ch]) ? (merged[CW-1:0] & cmp_mask) :
                                cmp_buf_ff[ch];
        // Outside the dual-slope modes the compare is not buffered
        wire [CW-1:0] nxt_act = ~dual ? cmp_buf_ff[ch] :
                                (load_ev ? cmp_buf_ff[ch] : cmp_act_ff[ch]);
        wire pwm_sel = (output_mode_sel[ch] == pwm16_pkg::COM_NONINV) |
                       (output_mode_sel[ch] == pwm16_pkg::COM_INV);
        // Toggle exists for channel A only; channel B code is reserved
        wire tog_sel = (ch == 0) & top_mode_bit & (output_mode_sel[ch] == pwm16_pkg::COM_TOGGLE);
        wire inv = output_mode_sel[ch] == pwm16_pkg::COM_INV;
        wire pwm_level = slope_up ? inv : ~inv;
        assign match[ch] = run & (count_value_ff == cmp_act_ff[ch]);
        assign connected[ch] = dual & (pwm_sel | tog_sel);
        assign nxt_oc[ch] = ~(match[ch] & connected[ch]) ? oc_ff[ch] :
                            (tog_sel ? ~oc_ff[ch] : pwm_level);

        // Buffer and active compare registers
        always_ff @(posedge clock) begin
            if (srst) begin
                cmp_buf_ff[ch] <= pwm16_pkg::CNT_BOTTOM;
                cmp_act_ff[ch] <= pwm16_pkg::CNT_BOTTOM;
            end else begin
                cmp_buf_ff[ch] <= nxt_buf;
                cmp_act_ff[ch] <= nxt_act;
            end
        end
    end

    // Flag set terms; a set in the same cycle as a clear wins
    logic [pwm16_pkg::FLAG_W-1:0] flag_set;
    always_comb begin
        flag_set = '0;
        flag_set[pwm16_pkg::FLAG_OVF] = bottom_ev;
        flag_set[pwm16_pkg::FLAG_CMPA] = match[0] | (top_ev & top_from_cmpa);
        flag_set[pwm16_pkg::FLAG_CMPB] = match[1];
        flag_set[pwm16_pkg::FLAG_CAP] = top_ev & top_from_cap;
    end
    wire [pwm16_pkg::FLAG_W-1:0] flag_clr = (wr_fire & sel_flags & byteenable[0]) ?
                                           writedata[pwm16_pkg::FLAG_W-1:0] : '0;
    wire [pwm16_pkg::FLAG_W-1:0] nxt_flags = (flags_ff & ~flag_clr) | flag_set;

    // Pin drive: level only when connected, driver only when direction is output
    wire nxt_pin_a = connected[0] & nxt_oc[0];
    wire nxt_pin_b = connected[1] & nxt_oc[1];
    assign compare_a_pin_out = pin_a_ff;
    assign compare_b_pin_out = pin_b_ff;
    assign compare_a_pin_oe = oe_a_ff;
    assign compare_b_pin_oe = oe_b_ff;

    // Read mux; unmapped words read as zero
    wire [DW-1:0] rd_mux = sel_ctrl ? ctrl_ff :
                           sel_count ? {{(DW-CW-1){1'b0}}, ~counting_up, count_value_ff} :
                           sel_cmp[0] ? {{(DW-CW){1'b0}}, cmp_buf_ff[0]} :
                           sel_cmp[1] ? {{(DW-CW){1'b0}}, cmp_buf_ff[1]} :
                           sel_cap ? {{(DW-CW){1'b0}}, capture_top_value_ff} :
                           sel_flags ? {{(DW-pwm16_pkg::FLAG_W){1'b0}}, flags_ff} :
                           sel_status ? {{(DW-pwm16_pkg::CHANNELS){1'b0}}, oc_ff} : '0;
    wire [DW-1:0] nxt_readdata = rd_load ? rd_mux : readdata_ff;

    // Bus and control registers
    always_ff @(posedge clock) begin
        if (srst) begin
            ack_ff <= 1'b0;
            ctrl_ff <= pwm16_pkg::CTRL_RESET;
            capture_top_value_ff <= pwm16_pkg::CNT_BOTTOM;
            readdata_ff <= '0;
        end else begin
            ack_ff <= nxt_ack;
            ctrl_ff <= nxt_ctrl;
            capture_top_value_ff <= nxt_cap;
            readdata_ff <= nxt_readdata;
        end
    end

    // Counter and direction, advanced only on ticks
    always_ff @(posedge clock) begin
        if (srst) begin
            count_value_ff <= pwm16_pkg::CNT_BOTTOM;
            dir_ff <= pwm16_pkg::DIR_UP;
        end else begin
            count_value_ff <= nxt_count;
            dir_ff <= nxt_dir;
        end
    end

    // Output levels, flags and pin registers
    always_ff @(posedge clock) begin
        if (srst) begin
            oc_ff <= '0;
            flags_ff <= '0;
            pin_a_ff <= 1'b0;
            pin_b_ff <= 1'b0;
            oe_a_ff <= 1'b0;
            oe_b_ff <= 1'b0;
        end else begin
            oc_ff <= nxt_oc;
            flags_ff <= nxt_flags;
            pin_a_ff <= nxt_pin_a;
            pin_b_ff <= nxt_pin_b;
            oe_a_ff <= pin_direction_a;
            oe_b_ff <= pin_direction_b;
        end
    end
endmodule : dual_slope_pwm_timer16

/* File: test/pwm_timer_props.sv */
// Port-level assertions for the dual-slope timer
`timescale 1ns/1ps
module pwm_timer_props (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Register bus
    input wire logic [pwm16_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [pwm16_pkg::DATA_W-1:0] readdata,
    input wire logic waitrequest,
    // Pin driver enables
    input wire logic compare_a_pin_oe,
    input wire logic compare_b_pin_oe
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    // Completed transfers; enables may move one or two edges after the control write lands
    wire logic rd_done = read && !waitrequest;
    wire logic wr_ctrl = write && !waitrequest && address == pwm16_pkg::REG_CTRL;
    // Bus handshake: exactly one wait cycle per request
    first_wait_a: assert property ($rose(read || write) |-> waitrequest)
        else $error("request answered without a wait cycle");
    one_wait_a: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("wait lasted more than one cycle");
    idle_ready_a: assert property (!(read || write) |-> !waitrequest)
        else $error("waitrequest high with no request");
    rdata_hold_a: assert property ($changed(readdata) |-> rd_done)
        else $error("readdata moved outside a read");
    // Pin drivers follow the direction bits only
    oe_a_cause_a: assert property ($changed(compare_a_pin_oe) |-> $past(wr_ctrl) || $past(wr_ctrl, 2))
        else $error("pin A enable moved without a control write");
    oe_b_cause_a: assert property ($changed(compare_b_pin_oe) |-> $past(wr_ctrl) || $past(wr_ctrl, 2))
        else $error("pin B enable moved without a control write");
    // Unused places read as zero
    unmapped_zero_a: assert property (rd_done && address == 3'h7 |-> readdata == '0)
        else $error("unmapped index read nonzero");
    ctrl_spare_a: assert property (rd_done && address == pwm16_pkg::REG_CTRL |-> (readdata & ~pwm16_pkg::CTRL_MASK) == '0)
        else $error("control spare bits read nonzero");
endmodule : pwm_timer_props
bind dual_slope_pwm_timer16 pwm_timer_props pwm_timer_props_inst (.clock(clock), .srst(srst), .address(address),
    .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
    .compare_a_pin_oe(compare_a_pin_oe), .compare_b_pin_oe(compare_b_pin_oe));

/* File: test/pin_load_model.sv */
// Behavioural motor-driver input: resolves the pin and totals its high time
`timescale 1ns/1ps
module pin_load_model (
    // Clock
    input wire logic clock,
    // Pin driver
    input wire logic pin_out,
    input wire logic pin_oe,
    // Observed load state
    output logic level,
    output int unsigned high_cnt
);
    // The load pulls a released pin down, so it never keeps the last driven level
    assign level = pin_oe ? pin_out : 1'b0;
    // Running total of high cycles; the bench reads differences
    initial high_cnt = 0;
    always @(posedge clock) begin
        if (level === 1'b1) begin
            high_cnt <= high_cnt + 1;
        end
    end
endmodule : pin_load_model

/* File: test/tb_dual_slope_pwm_timer16.sv */
// Self-checking bench for the dual-slope timer
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_dual_slope_pwm_timer16;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [2:0] address = 3'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'hf;
    logic [31:0] readdata, q;
    logic waitrequest, a_out, a_oe, b_out, b_oe, a_lvl, b_lvl;
    int unsigned a_hi, b_hi;
    int mismatches = 0;
    int checks_done = 0;
    // Design and one load per pin
    dual_slope_pwm_timer16 dual_slope_pwm_timer16_inst (.clock(clock), .srst(srst), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .compare_a_pin_out(a_out), .compare_a_pin_oe(a_oe),
        .compare_b_pin_out(b_out), .compare_b_pin_oe(b_oe));
    pin_load_model pin_load_model_inst (.clock(clock), .pin_out(a_out), .pin_oe(a_oe), .level(a_lvl), .high_cnt(a_hi));
    pin_load_model pin_load_model_b_inst (.clock(clock), .pin_out(b_out), .pin_oe(b_oe), .level(b_lvl), .high_cnt(b_hi));
    initial forever #4 clock = ~clock;
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict
    // One Avalon transfer, held until waitrequest is sampled low; a bounded wait
    task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d, output logic [31:0] rd);
        int n;
        n = 0;
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 64);
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
        if (waitrequest !== 1'b0) begin
            mismatches++;
            $display("[ERR] %0t bus wait timed out", $time);
            print_verdict();
        end else begin
            @(posedge clock);
        end
    endtask : bus
    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask : wr
    // Top of the count for a waveform mode
    function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] cap, ca);
        case (m)
            pwm16_pkg::WGM_PC_8: return pwm16_pkg::TOP_8;
            pwm16_pkg::WGM_PC_9: return pwm16_pkg::TOP_9;
            pwm16_pkg::WGM_PC_10: return pwm16_pkg::TOP_10;
            pwm16_pkg::WGM_PFC_CAP, pwm16_pkg::WGM_PC_CAP: return cap;
            default: return ca;
        endcase
    endfunction : top_of
    // High clocks over two periods: a match costs no clock, top and bottom hold one tick each
    function automatic int unsigned exp_hi(input int unsigned top, cmp, n, input logic [1:0] com, input logic dir);
        if (!dir) return 0;
        case (com)
            pwm16_pkg::COM_TOGGLE: return 2 * n * top;
            pwm16_pkg::COM_NONINV: return 4 * n * cmp;
            pwm16_pkg::COM_INV: return 4 * n * (top - cmp);
            default: return 0;
        endcase
    endfunction : exp_hi
    // Program stopped, start, settle two periods, measure two periods, then stop and check flags
    task automatic run_case(input logic [3:0] m, input logic [2:0] cs, input logic [15:0] cap, ca, cb,
                            input logic [1:0] coma, comb, input logic dirb);
        logic [15:0] top, cam;
        logic [1:0] effa;
        int unsigned n, a0, b0;
        logic [31:0] ctrl;
        n = (cs == pwm16_pkg::CS_DIV8) ? 8 : 1;
        ctrl = {19'h0, dirb, 1'b1, 3'h0, comb, coma, m};
        top = top_of(m, cap, ca);
        cam = m[3] ? ca : (ca & top);
        effa = (coma == pwm16_pkg::COM_TOGGLE && !m[3]) ? 2'h0 : coma;
        // Unbuffered mode first, so active compares (and a compare-A top) start from the new values
        wr(pwm16_pkg::REG_CTRL, {ctrl[31:4], 4'h0});
        wr(pwm16_pkg::REG_CMP_A, {16'h0, ca});
        wr(pwm16_pkg::REG_CMP_B, {16'h0, cb});
        wr(pwm16_pkg::REG_CTRL, ctrl);
        wr(pwm16_pkg::REG_COUNT, 32'h0);
        wr(pwm16_pkg::REG_CAP_TOP, {16'h0, cap});
        wr(pwm16_pkg::REG_CMP_A, {16'h0, ca});
        wr(pwm16_pkg::REG_CMP_B, {16'h0, cb});
        bus(1'b0, pwm16_pkg::REG_CMP_A, 32'h0, q);
        `CHK(q[15:0], cam)
        wr(pwm16_pkg::REG_CTRL, {ctrl[31:11], cs, ctrl[7:0]});
        repeat (4 * n * top + 16) @(posedge clock);
        a0 = a_hi;
        b0 = b_hi;
        repeat (4 * n * top) @(posedge clock);
        `CHK(a_hi - a0, exp_hi(top, cam, n, effa, 1'b1))
        `CHK(b_hi - b0, exp_hi(top, cb, n, comb, dirb))
        `CHK(b_oe, dirb)
        `CHK(a_oe, 1'b1)
        bus(1'b0, pwm16_pkg::REG_COUNT, 32'h0, q);
        `CHK(q[15:0] <= top, 1'b1)
        wr(pwm16_pkg::REG_CTRL, ctrl);
        bus(1'b0, pwm16_pkg::REG_FLAGS, 32'h0, q);
        `CHK(q[3:0], {m == pwm16_pkg::WGM_PFC_CAP || m == pwm16_pkg::WGM_PC_CAP, 3'h7})
        wr(pwm16_pkg::REG_FLAGS, 32'hf);
        bus(1'b0, pwm16_pkg::REG_FLAGS, 32'h0, q);
        `CHK(q[3:0], 4'h0)
        $display("test mode %0d done", m);
    endtask : run_case
    // Main sequence: reset, unmapped index, then one case per dual-slope mode, mode 1 twice, with corner compares
    initial begin
        logic [15:0] t;
        void'($urandom(32'hdfac));
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        bus(1'b0, pwm16_pkg::REG_CTRL, 32'h0, q);
        `CHK(q, 32'h0)
        wr(3'h7, 32'hffff_ffff);
        bus(1'b0, 3'h7, 32'h0, q);
        `CHK(q, 32'h0)
        $display("test reset done");
        t = 16'(3 + $urandom % 198);
        run_case(pwm16_pkg::WGM_PC_8, 3'h1, t, 16'($urandom), 16'h0, 2'h2, 2'h2, 1'b1);
        run_case(pwm16_pkg::WGM_PC_9, 3'h1, t, 16'h01ff, 16'($urandom % 512), 2'h2, 2'h3, 1'b1);
        run_case(pwm16_pkg::WGM_PC_10, 3'h1, t, 16'($urandom), 16'h03ff, 2'h3, 2'h3, 1'b1);
        run_case(pwm16_pkg::WGM_PC_CAP, 3'h1, t, 16'($urandom % (t + 1)), 16'($urandom % (t + 1)), 2'h2, 2'h3, 1'b1);
        run_case(pwm16_pkg::WGM_PC_CMPA, 3'h1, t, t, 16'($urandom % (t + 1)), 2'h1, 2'h2, 1'b1);
        run_case(pwm16_pkg::WGM_PFC_CAP, 3'h1, t, t, 16'h0, 2'h2, 2'h3, 1'b1);
        run_case(pwm16_pkg::WGM_PFC_CMPA, 3'h2, t, t, 16'($urandom % (t + 1)), 2'h1, 2'h3, 1'b0);
        run_case(pwm16_pkg::WGM_PC_8, 3'h1, t, 16'($urandom), 16'($urandom % 256), 2'h1, 2'h2, 1'b1);
        print_verdict();
    end
endmodule : tb_dual_slope_pwm_timer16
